// ===== cmcu_cond_eval.v
`timescale 1ns/1ps
`include "cmcu_defs.vh"
// evaluates one condition nibble against the flag vector
module cmcu_cond_eval
(
   input wire [3:0] condCode, // low nibble of second opcode byte
   input wire [5:0] flags, // current status flags
   output reg condTrue // condition holds
);
   wire carry = flags[`CMCU_FL_CARRY]; // carry_flag
   wire parity = flags[`CMCU_FL_PARITY]; // parity_flag
   wire zero = flags[`CMCU_FL_ZERO]; // zero_flag
   wire sign = flags[`CMCU_FL_SIGN]; // sign_flag
   wire ovf = flags[`CMCU_FL_OVF]; // overflow_flag

   // one entry per opcode; alias names share an entry by construction
   always @*
   begin
      case (condCode)
         `CMCU_CC_O: condTrue = ovf;
         `CMCU_CC_NO: condTrue = ~ovf;
         `CMCU_CC_B: condTrue = carry;
         `CMCU_CC_AE: condTrue = ~carry;
         `CMCU_CC_E: condTrue = zero;
         `CMCU_CC_NE: condTrue = ~zero;
         `CMCU_CC_BE: condTrue = carry | zero;
         `CMCU_CC_A: condTrue = ~carry & ~zero;
         `CMCU_CC_S: condTrue = sign;
         `CMCU_CC_NS: condTrue = ~sign;
         `CMCU_CC_P: condTrue = parity;
         `CMCU_CC_NP: condTrue = ~parity;
         `CMCU_CC_L: condTrue = sign ^ ovf;
         `CMCU_CC_GE: condTrue = ~(sign ^ ovf);
         `CMCU_CC_LE: condTrue = zero | (sign ^ ovf);
         `CMCU_CC_G: condTrue = ~zero & ~(sign ^ ovf);
         default: condTrue = 1'b0;
      endcase
   end
endmodule

// ===== cmcu_defs.vh
`ifndef CMCU_DEFS_VH
`define CMCU_DEFS_VH
// opcode bytes
`define CMCU_OP_ESC 8'h0F
`define CMCU_OP_COND_MOVE_HI 4'h4
`define CMCU_OP_COMPARE_ACC8 8'h3C
`define CMCU_OP_COMPARE_ACCV 8'h3D
`define CMCU_OP_GRP1_B 8'h80
`define CMCU_OP_GRP1_V 8'h81
`define CMCU_OP_GRP1_SX 8'h83
`define CMCU_OP_COMPARE_RM_R8 8'h38
`define CMCU_OP_COMPARE_RM_RV 8'h39
`define CMCU_OP_COMPARE_R_RM8 8'h3A
`define CMCU_OP_COMPARE_R_RMV 8'h3B
`define CMCU_REG_COMPARE 3'h7
// condition nibble codes
`define CMCU_CC_O 4'h0
`define CMCU_CC_NO 4'h1
`define CMCU_CC_B 4'h2
`define CMCU_CC_AE 4'h3
`define CMCU_CC_E 4'h4
`define CMCU_CC_NE 4'h5
`define CMCU_CC_BE 4'h6
`define CMCU_CC_A 4'h7
`define CMCU_CC_S 4'h8
`define CMCU_CC_NS 4'h9
`define CMCU_CC_P 4'hA
`define CMCU_CC_NP 4'hB
`define CMCU_CC_L 4'hC
`define CMCU_CC_GE 4'hD
`define CMCU_CC_LE 4'hE
`define CMCU_CC_G 4'hF
// flag vector positions
`define CMCU_FL_CARRY 0
`define CMCU_FL_PARITY 1
`define CMCU_FL_AUX 2
`define CMCU_FL_ZERO 3
`define CMCU_FL_SIGN 4
`define CMCU_FL_OVF 5
`define CMCU_FL_RESET 6'h00
// fault codes
`define CMCU_FLT_NONE 3'h0
`define CMCU_FLT_GENPROT 3'h1
`define CMCU_FLT_SS 3'h2
`define CMCU_FLT_PAGE 3'h3
`define CMCU_FLT_ALIGN 3'h4
`define CMCU_FLT_UD 3'h5
// operating modes
`define CMCU_MODE_REAL 2'h0
`define CMCU_MODE_PROT 2'h1
`define CMCU_MODE_V86 2'h2
`define CMCU_CPL_USER 2'h3
`endif

// ===== cmcu_exec_asserts.sv
`timescale 1ns/1ps
// watches the execution unit from its ports only
module cmcu_exec_asserts
(
   input wire logic ref_clk, // core clock
   input wire logic resetn, // sync reset, active low
   input wire logic issueValid, // issue pulse
   input wire logic [7:0] opByte0, // first opcode byte
   input wire logic [7:0] opByte1, // second opcode byte
   input wire logic opSize32, // operand size
   input wire logic srcIsMem, // memory operand
   input wire logic segLimitViol, // segment limit overrun
   input wire logic [31:0] srcValue, // move source
   input wire logic [5:0] flagsIn, // incoming flags
   input wire logic [15:0] pageFaultCode, // paging error code
   input wire logic doneValid_q, // result pulse
   input wire logic wbEnable_q, // destination write
   input wire logic [31:0] wbData_q, // write data
   input wire logic flagsWrite_q, // flag update
   input wire logic [2:0] faultCode_q, // fault kind
   input wire logic [15:0] faultErrCode_q // fault error code
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // register-source move, so no fault can mask the outcome
   wire isMove = issueValid && opByte0 == 8'h0F && opByte1[7:4] == 4'h4 && !srcIsMem;
   property p_answer; issueValid |=> doneValid_q; endproperty
   a_answer: assert property (p_answer) else $error("no result one cycle after issue");
   property p_idle; !issueValid |=> !doneValid_q && !wbEnable_q && !flagsWrite_q; endproperty
   a_idle: assert property (p_idle) else $error("output pulse without issue");
   property p_ovf; isMove && opByte1[3:0] == 4'h0 && flagsIn[5] |=> wbEnable_q; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow move skipped");
   property p_noovf; isMove && opByte1[3:0] == 4'h1 && flagsIn[5] |=> !wbEnable_q; endproperty
   a_noovf: assert property (p_noovf) else $error("no-overflow move taken");
   property p_nz; isMove && opByte1[3:0] == 4'h5 && flagsIn[3] |=> !wbEnable_q; endproperty
   a_nz: assert property (p_nz) else $error("nonzero move taken with zero set");
   property p_keep; isMove |=> !flagsWrite_q; endproperty
   a_keep: assert property (p_keep) else $error("move touched flags");
   property p_data; isMove && opSize32 |=> !wbEnable_q || wbData_q == $past(srcValue); endproperty
   a_data: assert property (p_data) else $error("move data wrong");
   property p_compare;
      issueValid && opByte0 == 8'h39 && !srcIsMem |=> !wbEnable_q && flagsWrite_q;
   endproperty
   a_compare: assert property (p_compare) else $error("compare wrote or kept flags");
   property p_seg;
      issueValid && opByte0 == 8'h0F && opByte1[7:4] == 4'h4 && srcIsMem && segLimitViol
         |=> faultCode_q == 3'h1 && !wbEnable_q;
   endproperty
   a_seg: assert property (p_seg) else $error("limit overrun not faulted");
   property p_pfc; faultCode_q == 3'h3 |-> faultErrCode_q == $past(pageFaultCode); endproperty
   a_pfc: assert property (p_pfc) else $error("page fault code wrong");
   c_move: cover property (isMove ##1 wbEnable_q);
   c_compare: cover property (issueValid && opByte0 == 8'h83 ##1 flagsWrite_q);
   c_align: cover property (faultCode_q == 3'h4);
endmodule

// ===== cmcu_exec_unit.v
`timescale 1ns/1ps
`include "cmcu_defs.vh"
// Notes on behaviour
// - move on not-overflow when overflow clear
// - not-parity/parity-odd moves when parity clear
// - not-sign moves when sign clear
// - not-zero moves when zero clear
// - parity/parity-even moves when parity set
// - false condition keeps destination, flags untouched
// - only 16/32-bit, reg or memory source
// - no 8-bit conditional move
// - alias names share one opcode
// - segment limit overrun gives general protection
// - protected null data selector faults
// - stack limit overrun gives stack fault
// - paging error gives page fault outside real mode; ignored in real mode
// - protected alignment fault only at CPL 3
// - v86 alignment fault without privilege test
// - compare subtracts, flags like subtract, no write
// - immediates sign-extended to first operand width
// - compare sets all six arithmetic flags
// - compare decoded in three opcode groups
module cmcu_exec_unit
(
   input wire ref_clk, // core clock
   input wire resetn, // synchronous reset, active low
   input wire issueValid, // one-cycle pulse: instruction issued
   input wire [7:0] opByte0, // first opcode byte
   input wire [7:0] opByte1, // second byte (after escape)
   input wire [2:0] modrmReg, // reg field of the modrm byte
   input wire opSize32, // operand size: 1 = 32-bit, 0 = 16-bit
   input wire srcIsMem, // second operand comes from memory
   input wire [31:0] dstValue, // current value of destination / first operand
   input wire [31:0] srcValue, // register or memory source value
   input wire [31:0] immValue, // raw immediate, low-aligned
   input wire [1:0] cpuMode, // real, protected or v86
   input wire [1:0] curPriv, // current privilege level
   input wire alignCheckEn, // alignment checking enabled
   input wire memUnaligned, // memory access is unaligned
   input wire segLimitViol, // address beyond code/data/extra limit
   input wire stackLimitViol, // address beyond stack limit
   input wire nullDataSel, // data/extra selector is null
   input wire pageFaultIn, // paging reported a miss or violation
   input wire [15:0] pageFaultCode, // paging error code
   input wire [5:0] flagsIn, // status_flag_register arithmetic bits
   output reg doneValid_q, // one-cycle pulse: result ready
   output reg wbEnable_q, // write destination register
   output reg [31:0] wbData_q, // destination write data
   output reg flagsWrite_q, // status flags update
   output reg [5:0] flagsOut_q, // new flag values
   output reg [2:0] faultCode_q, // fault kind, none when zero
   output reg [15:0] faultErrCode_q // error code carried with fault
);
   // the whole unit is one pipeline stage: inputs are decoded, evaluated and
   // checked for faults in the issue cycle, and every outcome is registered.
   // the result therefore always appears exactly one clock after issue, so
   // the issuing logic never has to wait or hold anything past one edge.
   // back-to-back issue is allowed because no state is kept between ops,
   // apart from the last write data and the last computed flags.

   // decode
   // conditional_move: escape byte, then any second byte 40h..4Fh.
   // alias names are not decoded separately; they are the same byte.
   wire isCondMove = (opByte0 == `CMCU_OP_ESC) &&
                     (opByte1[7:4] == `CMCU_OP_COND_MOVE_HI);
   // compare_op, accumulator against an immediate
   wire isCompareAcc = (opByte0 == `CMCU_OP_COMPARE_ACC8) ||
                       (opByte0 == `CMCU_OP_COMPARE_ACCV);
   // immediate group: the modrm reg field picks the operation
   wire isGrp1 = (opByte0 == `CMCU_OP_GRP1_B) || (opByte0 == `CMCU_OP_GRP1_V) ||
                 (opByte0 == `CMCU_OP_GRP1_SX);
   // only reg field 7 is ours; the rest of the group lives elsewhere
   wire isCompareImm = isGrp1 && (modrmReg == `CMCU_REG_COMPARE);
   // register forms share the top six opcode bits
   wire isCompareReg = (opByte0[7:2] == 6'b001110); // 38h..3Bh
   wire isCompare = isCompareAcc || isCompareImm || isCompareReg;
   // byte forms: 3C, 80, 38, 3A
   wire compareByte = (opByte0 == `CMCU_OP_COMPARE_ACC8) ||
                      (opByte0 == `CMCU_OP_GRP1_B) ||
                      (opByte0 == `CMCU_OP_COMPARE_RM_R8) ||
                      (opByte0 == `CMCU_OP_COMPARE_R_RM8);
   // operand order: 3A/3B compare reg minus r/m, others r/m minus reg
   wire regFirst = (opByte0 == `CMCU_OP_COMPARE_R_RM8) ||
                   (opByte0 == `CMCU_OP_COMPARE_R_RMV);
   // forms that carry only one immediate byte
   wire useImm8 = (opByte0 == `CMCU_OP_COMPARE_ACC8) || (opByte0 == `CMCU_OP_GRP1_B) ||
                  (opByte0 == `CMCU_OP_GRP1_SX);

   // condition evaluation
   wire condTrue;
   cmcu_cond_eval condEval
   (
      .condCode(opByte1[3:0]),
      .flags(flagsIn),
      .condTrue(condTrue)
   );

   // sign-extend an immediate to 32 bits from byte or word
   function [31:0] sext;
      input [31:0] raw;
      input isByte;
      input isWord;
      begin
         if (isByte)
         begin
            sext = {{24{raw[7]}}, raw[7:0]};
         end
         else if (isWord)
         begin
            sext = {{16{raw[15]}}, raw[15:0]};
         end
         else
         begin
            sext = raw;
         end
      end
   endfunction

   // width mask for the operand size in use
   function [31:0] widthMask;
      input isByte;
      input is32;
      begin
         if (isByte)
         begin
            widthMask = 32'h0000_00FF;
         end
         else if (is32)
         begin
            widthMask = 32'hFFFF_FFFF;
         end
         else
         begin
            widthMask = 32'h0000_FFFF;
         end
      end
   endfunction

   // second operand: immediate extended to first operand width
   // the 83h form extends one byte to 16 or 32 bits, so the byte test
   // comes before the word test in the helper.
   wire [31:0] immExt = sext(immValue, useImm8, ~opSize32);
   // everything above the operand width is masked off, so stale upper bits
   // of a register never reach the flags.
   wire [31:0] opMask = widthMask(compareByte, opSize32);
   wire [31:0] opA = (regFirst ? srcValue : dstValue) & opMask;
   wire [31:0] opBraw = (isCompareAcc || isCompareImm) ? immExt :
                        (regFirst ? dstValue : srcValue);
   wire [31:0] opB = opBraw & opMask;

   // subtract; result never leaves the block
   // a 33-bit subtract gives the 32-bit borrow; the narrow widths take their
   // borrow from a plain compare below, which costs a little more logic
   // but avoids a separate subtracter per width.
   wire [32:0] diff = {1'b0, opA} - {1'b0, opB};
   wire [31:0] res = diff[31:0] & opMask;
   wire [4:0] nib = {1'b0, opA[3:0]} - {1'b0, opB[3:0]};

   // msb index by width
   reg signA;
   reg signB;
   reg signR;
   reg borrow;
   always @*
   begin
      signA = opA[31];
      signB = opB[31];
      signR = res[31];
      borrow = diff[32];
      if (compareByte)
      begin
         signA = opA[7];
         signB = opB[7];
         signR = res[7];
         borrow = (opA[7:0] < opB[7:0]);
      end
      else if (!opSize32)
      begin
         signA = opA[15];
         signB = opB[15];
         signR = res[15];
         borrow = (opA[15:0] < opB[15:0]);
      end
   end

   // flags as a subtract would leave them
   // parity looks at the low byte only, whatever the width;
   // aux carry is the borrow out of the low nibble.
   wire [5:0] subFlags;
   assign subFlags[`CMCU_FL_CARRY] = borrow;
   assign subFlags[`CMCU_FL_PARITY] = ~^res[7:0];
   assign subFlags[`CMCU_FL_AUX] = nib[4];
   assign subFlags[`CMCU_FL_ZERO] = (res == 32'h0000_0000);
   assign subFlags[`CMCU_FL_SIGN] = signR;
   assign subFlags[`CMCU_FL_OVF] = (signA ^ signB) & (signA ^ signR);

   // fault priority: limit, null selector, stack, page, alignment
   // faults are only possible with a memory operand; register-only forms
   // never fault here. the fault causes are levels from the memory stage
   // in this same clock domain, so they are read without synchronising.
   // only one fault is reported; the order picks the first that applies.
   reg [2:0] fault;
   always @*
   begin
      fault = `CMCU_FLT_NONE;
      if (srcIsMem)
      begin
         if (segLimitViol)
         begin
            fault = `CMCU_FLT_GENPROT;
         end
         else if (cpuMode == `CMCU_MODE_PROT && nullDataSel)
         begin
            // a null selector is legal outside protected mode
            fault = `CMCU_FLT_GENPROT;
         end
         else if (stackLimitViol)
         begin
            fault = `CMCU_FLT_SS;
         end
         else if (pageFaultIn && cpuMode != `CMCU_MODE_REAL)
         begin
            // paging is off in real mode, so a stray report is ignored
            fault = `CMCU_FLT_PAGE;
         end
         else if (alignCheckEn && memUnaligned && cpuMode == `CMCU_MODE_PROT &&
                  curPriv == `CMCU_CPL_USER)
         begin
            // supervisor code may touch unaligned data freely
            fault = `CMCU_FLT_ALIGN;
         end
         else if (alignCheckEn && memUnaligned && cpuMode == `CMCU_MODE_V86)
         begin
            // v86 code always runs at user level, so no privilege test
            fault = `CMCU_FLT_ALIGN;
         end
      end
   end

   // unsupported: nothing this block decodes, or a byte-width move
   // there is no byte move encoding at all, so the byte case needs no gate
   wire unsupported = !(isCondMove || isCompare);

   // result registers; a faulting op neither writes nor touches flags
   // the strobes fall back to zero every cycle, so each lasts one clock;
   // write data and flags hold their last value, which saves enables on
   // the wide registers but means they are only meaningful with a strobe.
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         doneValid_q <= 1'b0;
         wbEnable_q <= 1'b0;
         wbData_q <= 32'h0000_0000;
         flagsWrite_q <= 1'b0;
         flagsOut_q <= `CMCU_FL_RESET;
         faultCode_q <= `CMCU_FLT_NONE;
         faultErrCode_q <= 16'h0000;
      end
      else
      begin
         doneValid_q <= issueValid;
         wbEnable_q <= 1'b0;
         flagsWrite_q <= 1'b0;
         faultCode_q <= `CMCU_FLT_NONE;
         faultErrCode_q <= 16'h0000;
         if (issueValid)
         begin
            if (unsupported)
            begin
               // only 16/32-bit moves and the listed compares exist
               faultCode_q <= `CMCU_FLT_UD;
            end
            else if (fault != `CMCU_FLT_NONE)
            begin
               faultCode_q <= fault;
               // error code zero except page fault
               faultErrCode_q <= (fault == `CMCU_FLT_PAGE) ? pageFaultCode : 16'h0000;
            end
            else if (isCondMove)
            begin
               // false condition: no write, flags never changed
               wbEnable_q <= condTrue;
               wbData_q <= opSize32 ? srcValue : {16'h0000, srcValue[15:0]};
            end
            else
            begin
               // compare: flags only, no destination write
               flagsWrite_q <= 1'b1;
               flagsOut_q <= subFlags;
            end
         end
      end
   end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
   reg ref_clk = 1'b0; // 200 MHz core clock
   reg resetn = 1'b0; // held low at start
   reg issueValid = 1'b0; // issue pulse
   reg [7:0] opByte0 = 8'h00; // first opcode byte
   reg [7:0] opByte1 = 8'h00; // second opcode byte
   reg [2:0] modrmReg = 3'h0; // modrm reg field
   reg opSize32 = 1'b0; // operand size
   reg srcIsMem = 1'b0; // memory operand
   reg [31:0] dstValue = 32'h0000_0000; // first operand
   reg [31:0] srcValue = 32'h0000_0000; // source operand
   reg [31:0] immValue = 32'h0000_0000; // raw immediate
   reg [1:0] cpuMode = 2'h0; // operating mode
   reg [1:0] curPriv = 2'h0; // privilege level
   reg alignCheckEn = 1'b0, memUnaligned = 1'b0, segLimitViol = 1'b0; // fault causes
   reg stackLimitViol = 1'b0, nullDataSel = 1'b0, pageFaultIn = 1'b0; // fault causes
   reg [15:0] pageFaultCode = 16'h5A3C; // fixed paging code
   reg [5:0] flagsIn = 6'h00; // incoming flags
   wire doneValid_q, wbEnable_q, flagsWrite_q; // result pulses
   wire [31:0] wbData_q; // write data
   wire [5:0] flagsOut_q; // computed flags
   wire [2:0] faultCode_q; // fault kind
   wire [15:0] faultErrCode_q; // fault error code
   integer errors = 0; // mismatch count
   integer comparisons = 0; // comparison count
   cmcu_exec_unit dut_u (.ref_clk(ref_clk), .resetn(resetn), .issueValid(issueValid),
      .opByte0(opByte0), .opByte1(opByte1), .modrmReg(modrmReg), .opSize32(opSize32),
      .srcIsMem(srcIsMem), .dstValue(dstValue), .srcValue(srcValue), .immValue(immValue),
      .cpuMode(cpuMode), .curPriv(curPriv), .alignCheckEn(alignCheckEn),
      .memUnaligned(memUnaligned), .segLimitViol(segLimitViol), .stackLimitViol(stackLimitViol),
      .nullDataSel(nullDataSel), .pageFaultIn(pageFaultIn), .pageFaultCode(pageFaultCode),
      .flagsIn(flagsIn), .doneValid_q(doneValid_q), .wbEnable_q(wbEnable_q), .wbData_q(wbData_q),
      .flagsWrite_q(flagsWrite_q), .flagsOut_q(flagsOut_q), .faultCode_q(faultCode_q),
      .faultErrCode_q(faultErrCode_q));
   // half period of 2.5 ns
   always #2.5 ref_clk = ~ref_clk;
   task final_report;
      begin
         if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp)
         begin
            errors = errors + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // one issue, answer fixed at one cycle; env = mode, priv, align, unal, seg, stk, null, page
   task issue(input [7:0] b0, input [7:0] b1, input [2:0] r, input s32, input mem,
      input [31:0] d, input [31:0] s, input [31:0] i, input [5:0] f, input [9:0] env);
      begin
         @(posedge ref_clk);
         issueValid <= 1'b1;
         {opByte0, opByte1, modrmReg, opSize32, srcIsMem} <= {b0, b1, r, s32, mem};
         {dstValue, srcValue, immValue, flagsIn} <= {d, s, i, f};
         {cpuMode, curPriv, alignCheckEn, memUnaligned, segLimitViol, stackLimitViol,
            nullDataSel, pageFaultIn} <= env;
         @(posedge ref_clk);
         issueValid <= 1'b0;
         #1;
         chk(32'(doneValid_q), 32'h0000_0001);
         if (doneValid_q !== 1'b1)
            final_report;
      end
   endtask
   // subtract flags model: w 0 byte, 1 word, 2 dword
   function automatic [5:0] subf(input [31:0] a, input [31:0] b, input [1:0] w);
      reg [31:0] m;
      reg [31:0] r;
      reg [31:0] x;
      integer t;
      begin
         m = (w == 2'd0) ? 32'h0000_00FF : (w == 2'd1) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
         t = (w == 2'd0) ? 7 : (w == 2'd1) ? 15 : 31;
         r = (a - b) & m;
         x = a ^ b ^ r;
         subf = {(a[t] ^ b[t]) & (a[t] ^ r[t]), r[t], r == 32'h0000_0000, x[4], ~^r[7:0],
            (a & m) < (b & m)};
      end
   endfunction
   // k[1:0] flag, k[2] negated code, k[3] tested flag set, k[4] 32-bit; others opposite
   task t_move;
      integer k;
      reg [3:0] cc;
      reg [5:0] f;
      reg hit;
      begin
         for (k = 0; k < 32; k = k + 1)
         begin
            cc = ((k % 4 == 0) ? 4'h0 : (k % 4 == 1) ? 4'h4 : (k % 4 == 2) ? 4'h8 : 4'hA) |
               {3'b000, k[2]};
            f = 6'h01 << ((k % 4 == 0) ? 5 : (k % 4 == 1) ? 3 : (k % 4 == 2) ? 4 : 1);
            f = k[3] ? f : ~f;
            hit = k[3] ^ k[2];
            issue(8'h0F, {4'h4, cc}, 3'h0, k[4], 1'b0, 32'h1111_1111, 32'hCAFE_5678,
               32'h0000_0000, f, 10'h000);
            chk(32'(wbEnable_q), 32'(hit));
            chk(32'(flagsWrite_q), 32'h0000_0000);
            if (hit)
               chk(wbData_q, k[4] ? 32'hCAFE_5678 : 32'h0000_5678);
         end
         issue(8'h0F, 8'h47, 3'h0, 1'b1, 1'b0, 0, 32'h0000_0001, 0, 6'h00, 10'h000);
         chk(32'(wbEnable_q), 32'h0000_0001);
         issue(8'h0F, 8'h47, 3'h0, 1'b1, 1'b0, 0, 32'h0000_0001, 0, 6'h01, 10'h000);
         chk(32'(wbEnable_q), 32'h0000_0000);
      end
   endtask
   task cmp1(input [7:0] op, input [2:0] r, input [1:0] w, input [31:0] d, input [31:0] s,
      input [31:0] i, input [31:0] a, input [31:0] b);
      begin
         issue(op, 8'h00, r, w[1], 1'b0, d, s, i, 6'h00, 10'h000);
         chk(32'(flagsWrite_q), 32'h0000_0001);
         chk(32'(wbEnable_q), 32'h0000_0000);
         chk(32'(flagsOut_q), 32'(subf(a, b, w)));
      end
   endtask
   task flt(input [9:0] env, input [2:0] e);
      begin
         issue(8'h0F, 8'h44, 3'h0, 1'b1, 1'b1, 0, 32'h0000_0009, 0, 6'h08, env);
         chk(32'(faultCode_q), 32'(e));
         chk(32'(wbEnable_q), 32'(e == 3'h0));
         if (e == 3'h3)
            chk(32'(faultErrCode_q), 32'h0000_5A3C);
         else
            chk(32'(faultErrCode_q), 32'h0000_0000);
      end
   endtask
   initial
   begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      t_move;
      cmp1(8'h39, 3'h0, 2'd2, 32'h0000_0005, 32'h0000_0007, 0, 5, 7);
      cmp1(8'h3B, 3'h0, 2'd2, 1, 32'h8000_0000, 0, 32'h8000_0000, 1);
      cmp1(8'h3C, 3'h0, 2'd0, 32'hFFFF_FF80, 0, 1, 32'h0000_0080, 1);
      cmp1(8'h3D, 3'h0, 2'd1, 32'h0000_1234, 0, 32'hAAAA_1234, 32'h1234, 32'h1234);
      cmp1(8'h80, 3'h7, 2'd0, 32'h0000_0010, 0, 1, 32'h0000_0010, 1);
      cmp1(8'h81, 3'h7, 2'd2, 0, 0, 1, 0, 1);
      cmp1(8'h83, 3'h7, 2'd2, 32'hFFFF_FFFF, 0, 32'h0000_00FF, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      cmp1(8'h83, 3'h7, 2'd1, 32'h0000_FFFE, 0, 32'h0000_0080, 32'h0000_FFFE, 32'h0000_FF80);
      cmp1(8'h38, 3'h0, 2'd0, 5, 3, 0, 5, 3);
      cmp1(8'h3A, 3'h0, 2'd0, 3, 5, 0, 5, 3);
      flt({2'h1, 2'h0, 6'b001000}, 3'h1);
      flt({2'h1, 2'h3, 6'b111111}, 3'h1);
      flt({2'h1, 2'h0, 6'b000010}, 3'h1);
      flt({2'h0, 2'h0, 6'b000010}, 3'h0);
      flt({2'h0, 2'h0, 6'b000100}, 3'h2);
      flt({2'h2, 2'h3, 6'b000001}, 3'h3);
      flt({2'h1, 2'h3, 6'b110000}, 3'h4);
      flt({2'h1, 2'h2, 6'b110000}, 3'h0);
      flt({2'h2, 2'h0, 6'b110000}, 3'h4);
      issue(8'h80, 8'h00, 3'h2, 1'b1, 1'b0, 0, 0, 0, 6'h00, 10'h000);
      chk(32'(faultCode_q), 32'h0000_0005);
      final_report;
   end
endmodule
bind cmcu_exec_unit cmcu_exec_asserts chk_u (.ref_clk(ref_clk), .resetn(resetn),
   .issueValid(issueValid), .opByte0(opByte0), .opByte1(opByte1), .opSize32(opSize32),
   .srcIsMem(srcIsMem), .segLimitViol(segLimitViol), .srcValue(srcValue), .flagsIn(flagsIn),
   .pageFaultCode(pageFaultCode), .doneValid_q(doneValid_q), .wbEnable_q(wbEnable_q),
   .wbData_q(wbData_q), .flagsWrite_q(flagsWrite_q), .faultCode_q(faultCode_q),
   .faultErrCode_q(faultErrCode_q));
